// File: src/bsfs_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - soft-start begins 384 cycles after enable, supplies good and clock lock.
// - enable sink current stays on until soft-start begins, then switches off.
// - shutdown, fault or supply loss resets soft-start and changes both gates at once.
// - soft-start counter advances per phase pulse, full ramp after 2560 cycles.
// - modulator output blocked from gate drivers until first modulator pulse seen.
// - low-side drive held low for the first switching cycle after start.
// - precharge above target below 113% withholds switching until target and pulse.
// - enable low, precharge 113-120%: low-side on at 113%, off below 87%.
// - precharge above 120% latches the controller off, no power-up.
// - output ok flag stays low until soft-start has completed.
// - output ok drops on disable or window loss after three consecutive cycles.
// - undervoltage armed after soft-start; below -13% drops ok unless other fault.
// - overvoltage above 120% from soft-start latches high-side off, low-side until 87%.
// - latched overvoltage forces enable and ok low until bias supply cycles.
// - enable low and 113-120%: low-side on until below 87%, no latch.
// - over-temperature pulls shared enable low until the indication clears.
// - phase overcurrent declared after limit comparator high for 7 consecutive cycles.
// - share-bus comparator excess also declares overcurrent, independent path.
// - overcurrent pulls enable low and high-side drive off at once, low-side drive off by the next cycle.
// - after overcurrent wait three soft-start intervals, retry, repeat until cleared.
// - all modules pull shared enable low on a fault and treat low as disable.
// - leading-edge modulation with at least 350ns dead time every period.
// - sync missing for 13 cycles disables until lock returns, then fresh soft-start.
////////////////////////////////////////////////////////////////////////////////
package bsfs_pkg;
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned START_DELAY_CYCLES = 384;
   localparam int unsigned SOFT_START_CYCLES = 2560;
   localparam int unsigned OK_FILTER_CYCLES = 3;
   localparam int unsigned OC_FILTER_CYCLES = 7;
   localparam int unsigned HICCUP_INTERVALS = 3;
   localparam int unsigned SYNC_LOSS_CYCLES = 13;
   localparam int unsigned DEAD_TIME_NS = 350;
   // least time rounds up
   localparam int unsigned DEAD_TIME_CYCLES = (DEAD_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned CNT_W = 14;
   typedef enum logic [2:0] {BSFS_IDLE, BSFS_DELAY, BSFS_SOFT, BSFS_RUN, BSFS_HICCUP, BSFS_LATCHED} bsfs_state_t;
endpackage : bsfs_pkg

// File: src/bsfs_sequencer.sv
module bsfs_sequencer
   import bsfs_pkg::*;
#(
   parameter int unsigned START_DELAY = bsfs_pkg::START_DELAY_CYCLES,
   parameter int unsigned SS_CYCLES = bsfs_pkg::SOFT_START_CYCLES,
   parameter int unsigned OC_CYCLES = bsfs_pkg::OC_FILTER_CYCLES
)
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // phase clock and sync
   input wire logic phase_pulse_in,
   input wire logic sync_clock_input_in,
   input wire logic pll_lock_in,
   // supplies and enable
   input wire logic bias_por_ok_in,
   input wire logic input_por_ok_in,
   input wire logic enable_above_thr_in,
   // output monitor comparators
   input wire logic output_monitor_input_above_target_in,
   input wire logic output_monitor_input_above_113_in,
   input wire logic output_monitor_input_above_120_in,
   input wire logic output_monitor_input_below_87_in,
   input wire logic output_monitor_input_below_uv_in,
   input wire logic output_monitor_input_in_window_in,
   // protection comparators
   input wire logic over_temp_in,
   input wire logic phase_oc_in,
   input wire logic current_share_bus_oc_in,
   // modulator
   input wire logic modulator_pwm_in,
   // outputs
   output logic enable_pull_low_out,
   output logic enable_sink_on_out,
   output logic high_side_gate_drive_out,
   output logic low_side_gate_drive_out,
   output logic output_ok_flag_out,
   output logic soft_start_active_out,
   output logic [CNT_W-1:0] soft_start_level_out
);
   import bsfs_pkg::*;

   // the filter counter is three bits wide and the delay must fit the shared counter
   if (START_DELAY < 1 || START_DELAY >= (1 << CNT_W) || SS_CYCLES < 1 || SS_CYCLES >= (1 << (CNT_W - 2))
      || OC_CYCLES < 1 || OC_CYCLES > 7)
   begin : g_param_check
      $error("bsfs_sequencer: unsupported parameter values");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // two-flop synchronisers for every comparator and pin
   localparam int NSYNC = 16;
   logic [NSYNC-1:0] sync_a;
   logic [NSYNC-1:0] sync_b;
   wire [NSYNC-1:0] raw_in = {sync_clock_input_in, pll_lock_in, bias_por_ok_in, input_por_ok_in,
      enable_above_thr_in, output_monitor_input_above_target_in, output_monitor_input_above_113_in,
      output_monitor_input_above_120_in, output_monitor_input_below_87_in,
      output_monitor_input_below_uv_in, output_monitor_input_in_window_in, over_temp_in,
      phase_oc_in, current_share_bus_oc_in, modulator_pwm_in, phase_pulse_in};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++)
      begin : g_sync
         always_ff @(posedge ref_clk_in)
         begin
            if (!rst_n_in)
            begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
            end
            else
            begin
               sync_a[gi] <= raw_in[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate

   wire s_sync = sync_b[15];
   wire s_lock = sync_b[14];
   wire s_bias = sync_b[13];
   wire s_vin = sync_b[12];
   wire s_en = sync_b[11];
   wire s_tgt = sync_b[10];
   wire s_113 = sync_b[9];
   wire s_120 = sync_b[8];
   wire s_87 = sync_b[7];
   wire s_uv = sync_b[6];
   wire s_win = sync_b[5];
   wire s_ot = sync_b[4];
   wire s_poc = sync_b[3];
   wire s_boc = sync_b[2];
   wire s_pwm = sync_b[1];
   wire s_phase = sync_b[0];

   ////////////////////////////////////////////////////////////////////////////////
   // state
   bsfs_state_t state;
   bsfs_state_t next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [1:0] hic_n;
   logic [3:0] sync_lost_cnt;
   logic [2:0] oc_cnt;
   logic [1:0] bad_cnt;
   logic phase_d;
   logic pwm_d;
   logic pwm_seen;
   logic first_cycle;
   logic ov_latch;
   logic ov_ls_on;
   logic pre120_latch;
   logic nl_ls_on;
   logic ot_hold;
   logic sync_lost;
   logic [3:0] dead_cnt;

   wire phase_edge = s_phase & ~phase_d;
   wire pwm_edge = s_pwm & ~pwm_d;
   wire sync_edge_gap = (sync_lost_cnt >= 4'(SYNC_LOSS_CYCLES));
   wire oc_phase = (oc_cnt >= 3'(OC_CYCLES));
   wire oc_fault = oc_phase | s_boc;
   wire supplies_ok = s_bias & s_vin & s_lock & ~sync_lost;
   wire local_fault = ov_latch | ot_hold | pre120_latch | ((state == BSFS_SOFT || state == BSFS_RUN) & oc_fault);
   // shared line seen low when others pull it, or we pull it
   wire shared_en = s_en & ~enable_pull_low_out;
   wire go = shared_en & supplies_ok & ~local_fault;
   wire ss_done = (cnt >= CNT_W'(SS_CYCLES - 1)) & phase_edge;
   wire ov_trip = s_120 & (state == BSFS_SOFT || state == BSFS_RUN);
   wire hold_pre = (state == BSFS_SOFT) & s_tgt & ~pwm_seen;
   wire ls_protect = ov_ls_on | nl_ls_on;
   wire switching = (state == BSFS_SOFT || state == BSFS_RUN) & pwm_seen & ~hold_pre & ~ov_latch;
   wire ok_bad = ~shared_en | ~s_win | ((state == BSFS_RUN) & s_uv & ~oc_fault & ~s_ot & s_lock & ~ov_latch);

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         BSFS_IDLE:
         begin
            next_cnt = '0;
            if (go)
               next_state = BSFS_DELAY;
         end
         BSFS_DELAY:
         begin
            next_cnt = cnt + 1'b1;
            if (!go)
               next_state = BSFS_IDLE;
            else if (cnt >= CNT_W'(START_DELAY - 1))
            begin
               next_state = BSFS_SOFT;
               next_cnt = '0;
            end
         end
         BSFS_SOFT:
         begin
            if (phase_edge)
               next_cnt = cnt + 1'b1;
            if (oc_fault)
            begin
               next_state = BSFS_HICCUP;
               next_cnt = '0;
            end
            else if (!go)
               next_state = BSFS_IDLE;
            else if (ss_done)
               next_state = BSFS_RUN;
         end
         BSFS_RUN:
         begin
            if (oc_fault)
            begin
               next_state = BSFS_HICCUP;
               next_cnt = '0;
            end
            else if (!go)
               next_state = BSFS_IDLE;
         end
         BSFS_HICCUP:
         begin
            if (phase_edge)
               next_cnt = cnt + 1'b1;
            if (ov_latch)
               next_state = BSFS_LATCHED;
            else if (cnt >= CNT_W'(SS_CYCLES - 1) && phase_edge)
            begin
               // each interval restarts the count, so the wait spans three full ramps
               next_cnt = '0;
               if (hic_n == 2'(HICCUP_INTERVALS))
                  next_state = BSFS_IDLE;
            end
         end
         BSFS_LATCHED:
         begin
            next_cnt = '0;
            // loss of bias is the only way out, the latch flops clear on it too
            if (!s_bias)
               next_state = BSFS_IDLE;
         end
         default:
            next_state = BSFS_IDLE;
      endcase
      if (ov_latch || pre120_latch)
         next_state = BSFS_LATCHED;
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         state <= BSFS_IDLE;
         cnt <= '0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // hiccup counts three soft-start intervals
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in || state != BSFS_HICCUP)
         hic_n <= 2'd1;
      else if (phase_edge && cnt >= CNT_W'(SS_CYCLES - 1) && hic_n != 2'(HICCUP_INTERVALS))
         hic_n <= hic_n + 2'd1;
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         phase_d <= 1'b0;
         pwm_d <= 1'b0;
      end
      else
      begin
         phase_d <= s_phase;
         pwm_d <= s_pwm;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // start-up gating of the modulator
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in || state != BSFS_SOFT && state != BSFS_RUN)
      begin
         pwm_seen <= 1'b0;
         first_cycle <= 1'b1;
      end
      else
      begin
         if (pwm_edge && !(s_tgt && state == BSFS_SOFT && !pwm_seen && s_tgt))
            pwm_seen <= 1'b1;
         if (pwm_seen && phase_edge)
            first_cycle <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sync loss and filters
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         sync_lost_cnt <= '0;
         sync_lost <= 1'b0;
         oc_cnt <= '0;
         bad_cnt <= '0;
      end
      else
      begin
         if (s_sync)
            sync_lost_cnt <= '0;
         else if (!sync_edge_gap)
            sync_lost_cnt <= sync_lost_cnt + 4'd1;
         if (sync_edge_gap)
            sync_lost <= 1'b1;
         else if (s_lock && s_sync)
            sync_lost <= 1'b0;
         if (!s_poc)
            oc_cnt <= '0;
         else if (phase_edge && !oc_phase)
            oc_cnt <= oc_cnt + 3'd1;
         if (!ok_bad)
            bad_cnt <= '0;
         else if (bad_cnt != 2'(OK_FILTER_CYCLES))
            bad_cnt <= bad_cnt + 2'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // overvoltage and temperature protection
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in || !s_bias)
      begin
         ov_latch <= 1'b0;
         ov_ls_on <= 1'b0;
         pre120_latch <= 1'b0;
      end
      else
      begin
         if (ov_trip)
         begin
            ov_latch <= 1'b1;
            ov_ls_on <= 1'b1;
         end
         else if (s_87)
            ov_ls_on <= 1'b0;
         if (s_120 && (state == BSFS_IDLE || state == BSFS_DELAY))
            pre120_latch <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         nl_ls_on <= 1'b0;
         ot_hold <= 1'b0;
      end
      else
      begin
         if (!shared_en && s_113 && !s_120)
            nl_ls_on <= 1'b1;
         else if (s_87)
            nl_ls_on <= 1'b0;
         ot_hold <= s_ot;
      end
   end

   // dead time after high-side falls
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in || high_side_gate_drive_out)
         dead_cnt <= 4'(DEAD_TIME_CYCLES);
      else if (dead_cnt != 4'd0)
         dead_cnt <= dead_cnt - 4'd1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registered outputs
   wire next_hs = switching & s_pwm & ~first_cycle & (dead_cnt == 4'd0 || high_side_gate_drive_out) & ~oc_fault;
   wire next_ls = ls_protect | (switching & ~first_cycle & ~s_pwm & ~high_side_gate_drive_out & (dead_cnt == 4'd0));

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         enable_pull_low_out <= 1'b0;
         enable_sink_on_out <= 1'b1;
         high_side_gate_drive_out <= 1'b0;
         low_side_gate_drive_out <= 1'b0;
         output_ok_flag_out <= 1'b0;
         soft_start_active_out <= 1'b0;
         soft_start_level_out <= '0;
      end
      else
      begin
         enable_pull_low_out <= ov_latch | ov_trip | ot_hold | pre120_latch | (next_state == BSFS_HICCUP);
         enable_sink_on_out <= ~(next_state == BSFS_SOFT || next_state == BSFS_RUN);
         high_side_gate_drive_out <= next_hs & ~ov_trip;
         low_side_gate_drive_out <= next_ls & ~(ov_latch & ~ov_ls_on);
         if (state != BSFS_RUN || bad_cnt == 2'(OK_FILTER_CYCLES) || ov_latch)
            output_ok_flag_out <= 1'b0;
         else if (!ok_bad)
            output_ok_flag_out <= 1'b1;
         soft_start_active_out <= (next_state == BSFS_SOFT);
         soft_start_level_out <= (next_state == BSFS_SOFT) ? next_cnt : ((next_state == BSFS_RUN) ? CNT_W'(SS_CYCLES) : '0);
      end
   end
endmodule : bsfs_sequencer

// File: verification/bsfs_sequencer_sva.sv
module bsfs_sequencer_sva
#(
   parameter int unsigned START_DELAY = 384,
   parameter int unsigned SS_CYCLES = 2560
)
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // watched inputs
   input wire logic sync_clock_input_in,
   input wire logic pll_lock_in,
   input wire logic bias_por_ok_in,
   input wire logic input_por_ok_in,
   input wire logic enable_above_thr_in,
   input wire logic output_monitor_input_above_120_in,
   input wire logic output_monitor_input_in_window_in,
   input wire logic over_temp_in,
   input wire logic phase_oc_in,
   input wire logic current_share_bus_oc_in,
   // watched outputs
   input wire logic enable_pull_low_out,
   input wire logic enable_sink_on_out,
   input wire logic high_side_gate_drive_out,
   input wire logic low_side_gate_drive_out,
   input wire logic output_ok_flag_out,
   input wire logic soft_start_active_out,
   input wire logic [bsfs_pkg::CNT_W-1:0] soft_start_level_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import bsfs_pkg::*;
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////////////////////////
   logic [15:0] good_cnt;
   logic [2:0] bad_cnt;
   logic [15:0] slow_hist;
   logic [15:0] fast_hist;
   wire all_good = enable_above_thr_in && bias_por_ok_in && input_por_ok_in && pll_lock_in && sync_clock_input_in;
   wire bad_now = !output_monitor_input_in_window_in || !enable_above_thr_in || enable_pull_low_out;
   // faults that may drop the flag without the three-cycle filter
   wire fault_now = !bias_por_ok_in || !input_por_ok_in || !pll_lock_in || !sync_clock_input_in || over_temp_in
      || output_monitor_input_above_120_in || phase_oc_in || current_share_bus_oc_in;
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         good_cnt <= 16'h0000;
         bad_cnt <= 3'h0;
         slow_hist <= 16'h0000;
         fast_hist <= 16'h0000;
      end
      else
      begin
         good_cnt <= !all_good ? 16'h0000 : good_cnt + {15'h0000, good_cnt != 16'hffff};
         bad_cnt <= !bad_now ? 3'h0 : bad_cnt + {2'h0, bad_cnt != 3'h7};
         slow_hist <= {slow_hist[14:0], bad_now && bad_cnt >= 3'h2};
         fast_hist <= {fast_hist[14:0], fault_now};
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   start_delay_a: assert property ($rose(soft_start_active_out) |-> good_cnt >= START_DELAY)
      else $error("soft start began before the start delay");
   sink_off_a: assert property (soft_start_active_out |-> !enable_sink_on_out)
      else $error("enable sink on during soft start");
   ramp_max_a: assert property (soft_start_level_out <= SS_CYCLES)
      else $error("ramp count beyond full value");
   ok_in_soft_a: assert property (soft_start_active_out |-> !output_ok_flag_out)
      else $error("ok flag high during soft start");
   ok_filter_a: assert property ($fell(output_ok_flag_out) |-> (|slow_hist) || (|fast_hist))
      else $error("ok flag dropped without three bad cycles");
   pull_gates_a: assert property (enable_pull_low_out && $past(enable_pull_low_out) |-> !high_side_gate_drive_out)
      else $error("high side on while enable pulled low");
   no_overlap_a: assert property (!(high_side_gate_drive_out && low_side_gate_drive_out))
      else $error("both gates on together");
   // protective low-side turn-on with the shared enable low is immediate by design
   dead_time_a: assert property ($fell(high_side_gate_drive_out) |=> (!low_side_gate_drive_out || !enable_above_thr_in) [*8])
      else $error("low side on inside dead time");
   ov_high_off_a: assert property (output_monitor_input_above_120_in [*6] |-> !high_side_gate_drive_out)
      else $error("high side on during overvoltage");
   cover property ($rose(soft_start_active_out));
   cover property ($rose(output_ok_flag_out));
   cover property ($rose(enable_pull_low_out));
   cover property ($fell(high_side_gate_drive_out));
endmodule : bsfs_sequencer_sva

// File: verification/bsfs_peer_model.sv
module bsfs_peer_model
(
   // shared enable line
   input wire logic dut_pull_in,
   input wire logic fault_in,
   output logic enable_line_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // the line has a pull-up, so it reads high whenever no module sinks it
   assign enable_line_out = !(dut_pull_in || fault_in);
endmodule : bsfs_peer_model

// File: verification/buck_startup_fault_sequencer_bench.sv
module buck_startup_fault_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import bsfs_pkg::*;
   localparam int unsigned START_DELAY = 384;
   localparam int unsigned SS_CYCLES = 8;
   localparam int unsigned OC_CYCLES = 7;
   logic ref_clk_in = 1'h0;
   logic rst_n_in = 1'h0;
   logic phase_pulse_in = 1'h0;
   logic sync_clock_input_in = 1'h1;
   logic pll_lock_in = 1'h1;
   logic bias_por_ok_in = 1'h1;
   logic input_por_ok_in = 1'h1;
   logic over_temp_in = 1'h0;
   logic phase_oc_in = 1'h0;
   logic current_share_bus_oc_in = 1'h0;
   logic modulator_pwm_in = 1'h0;
   logic peer_fault = 1'h0;
   logic enable_above_thr_in, output_monitor_input_above_target_in, output_monitor_input_above_113_in;
   logic output_monitor_input_above_120_in, output_monitor_input_below_87_in, output_monitor_input_below_uv_in;
   logic output_monitor_input_in_window_in, enable_pull_low_out, enable_sink_on_out;
   logic high_side_gate_drive_out, low_side_gate_drive_out, output_ok_flag_out, soft_start_active_out;
   logic [CNT_W-1:0] soft_start_level_out;
   logic [1:0] phase_cnt = 2'h0;
   int seed = 58;
   int err_count = 0;
   int check_count = 0;
   int n;
   bsfs_sequencer #(.START_DELAY(START_DELAY), .SS_CYCLES(SS_CYCLES), .OC_CYCLES(OC_CYCLES)) u_dut (.*);
   bsfs_peer_model u_peer (.dut_pull_in(enable_pull_low_out), .fault_in(peer_fault),
      .enable_line_out(enable_above_thr_in));
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      forever #20 ref_clk_in = ~ref_clk_in;
   end
   // phase pulse every fourth cycle, modulator level random
   always @(posedge ref_clk_in)
   begin
      #1;
      phase_cnt = phase_cnt + 2'h1;
      phase_pulse_in = phase_cnt == 2'h0;
      modulator_pwm_in = 1'($random(seed));
   end
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk_in);
      #1;
   endtask : cyc
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk
   function automatic logic pick(input int sel);
      return sel == 0 ? soft_start_active_out : sel == 1 ? output_ok_flag_out : enable_pull_low_out;
   endfunction : pick
   task automatic wait_for(input int sel, input logic val, input int lim);
      n = 0;
      while (pick(sel) !== val && n < lim)
      begin
         cyc(1);
         n++;
      end
      chk("wait_done", n < lim, 1);
   endtask : wait_for
   // 0 in window, 1 above 120, 2 below 87 and uv, 3 out of window only
   task automatic set_out(input int lvl);
      output_monitor_input_above_target_in = lvl == 1;
      output_monitor_input_above_113_in = lvl == 1;
      output_monitor_input_above_120_in = lvl == 1;
      output_monitor_input_below_87_in = lvl == 2;
      output_monitor_input_below_uv_in = lvl == 2;
      output_monitor_input_in_window_in = lvl == 0;
   endtask : set_out
   task automatic start_up();
      wait_for(0, 1, 600);
      chk("start_delay", n >= START_DELAY && n <= START_DELAY + 8, 1);
      chk("sink_off", enable_sink_on_out, 0);
      chk("ok_in_soft", output_ok_flag_out, 0);
      wait_for(0, 0, 100);
      chk("ramp_len", n >= 4 * SS_CYCLES - 4 && n <= 4 * SS_CYCLES + 8, 1);
      chk("ramp_end", soft_start_level_out, 16'(SS_CYCLES));
      wait_for(1, 1, 50);
   endtask : start_up
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      set_out(0);
      cyc(2);
      chk("sink_rst", enable_sink_on_out, 1);
      rst_n_in = 1'h1;
      start_up();
      repeat (4)
      begin
         set_out(3);
         cyc(1 + ($random(seed) & 1));
         set_out(0);
         cyc(10);
         chk("ok_glitch", output_ok_flag_out, 1);
      end
      set_out(3);
      cyc(10);
      chk("ok_drop", output_ok_flag_out, 0);
      set_out(0);
      over_temp_in = 1'h1;
      wait_for(2, 1, 10);
      cyc(20);
      chk("ot_hold", enable_pull_low_out, 1);
      over_temp_in = 1'h0;
      wait_for(2, 0, 10);
      start_up();
      for (int k = 0; k < 2; k++)
      begin
         phase_oc_in = k == 0;
         current_share_bus_oc_in = k == 1;
         wait_for(2, 1, 60);
         chk("oc_filter", k == 1 ? n <= 8 : n >= 4 * OC_CYCLES - 4, 1);
         cyc(2);
         chk("oc_gates", {high_side_gate_drive_out, low_side_gate_drive_out}, 0);
         wait_for(2, 0, 300);
         chk("hiccup_len", n >= 12 * SS_CYCLES - 5, 1);
         wait_for(2, 1, 600);
         chk("retry_ok", output_ok_flag_out, 0);
         phase_oc_in = 1'h0;
         current_share_bus_oc_in = 1'h0;
         wait_for(2, 0, 300);
         start_up();
      end
      peer_fault = 1'h1;
      cyc(8);
      chk("peer_ok", output_ok_flag_out, 0);
      chk("peer_sink", enable_sink_on_out, 1);
      chk("peer_hs", high_side_gate_drive_out, 0);
      peer_fault = 1'h0;
      start_up();
      sync_clock_input_in = 1'h0;
      cyc(20);
      chk("sync_loss", {soft_start_active_out, output_ok_flag_out, high_side_gate_drive_out}, 0);
      sync_clock_input_in = 1'h1;
      start_up();
      set_out(1);
      cyc(16);
      chk("ov_trip", {high_side_gate_drive_out, low_side_gate_drive_out, enable_pull_low_out}, 3);
      set_out(2);
      cyc(14);
      chk("ov_low_off", low_side_gate_drive_out, 0);
      set_out(0);
      cyc(30);
      chk("ov_latch", {enable_pull_low_out, output_ok_flag_out}, 2);
      bias_por_ok_in = 1'h0;
      cyc(5);
      bias_por_ok_in = 1'h1;
      start_up();
      end_sim();
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk_in);
      err_count++;
      end_sim();
   end
endmodule : buck_startup_fault_sequencer_bench
bind bsfs_sequencer bsfs_sequencer_sva #(.START_DELAY(START_DELAY), .SS_CYCLES(SS_CYCLES)) u_sva (.*);
